// ### design/adrc_host.sv
// host controller driving an asynchronous page-mode dram module
`timescale 1ns/100ps
`default_nettype none

module adrc_host #(
  parameter int ROW_W = 10,
  parameter int DATA_W = 32,
  parameter int PWRUP_CYC = adrc_pkg::ADRC_PWRUP_CYC,
  parameter int SELF_CYC = adrc_pkg::ADRC_TSELF_CYC,
  parameter logic [1:0] BURST_MODE = 2'h0 // 0 distributed, 1 cbr burst, 2 row-only burst
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [2:0] reqCmd,
  input wire logic [ROW_W-1:0] reqRow,
  input wire logic [ROW_W-1:0] reqCol,
  input wire logic [DATA_W-1:0] reqData,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  output logic initDone,
  output logic rowStrobe_n,
  output logic colStrobe_n,
  output logic writeEnable_n,
  output logic outputEnable_n,
  output logic [ROW_W-1:0] addr,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe_n
);
  import adrc_pkg::*;

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rstMeta, rstSync;
  logic [DATA_W-1:0] dinMeta, dinSync;

  // reset release through two flops
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // read data pins pass two flops
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      dinMeta <= '0;
      dinSync <= '0;
    end
    else
    begin
      dinMeta <= dataIn;
      dinSync <= dinMeta;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  localparam int CNT_W = 32;
  adrc_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [3:0] dummy, next_dummy;
  logic [10:0] burst, next_burst;
  logic burstAfter, next_burstAfter;
  logic isWrite, next_isWrite, isRefresh, next_isRefresh, isHidden, next_isHidden;
  logic ras, next_ras, cas, next_cas, we, next_we, oe, next_oe, doe, next_doe;
  logic [ROW_W-1:0] next_addr, colAddr, next_colAddr;
  logic [DATA_W-1:0] next_dataOut, next_rspData;
  logic next_rspValid, next_initDone;

  // remaining count of a phase
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction : cyc

  // next-state and pin values
  always_comb
  begin
    next_state = state;
    next_cnt = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
    next_dummy = dummy;
    next_burst = burst;
    next_burstAfter = burstAfter;
    next_isWrite = isWrite;
    next_isRefresh = isRefresh;
    next_isHidden = isHidden;
    next_ras = ras;
    next_cas = cas;
    next_we = we;
    next_oe = oe;
    next_doe = doe;
    next_addr = addr;
    next_colAddr = colAddr;
    next_dataOut = dataOut;
    next_rspData = rspData;
    next_rspValid = 1'b0;
    next_initDone = initDone;
    reqReady = 1'b0;
    unique case (state)
      ADRC_POWERUP:
        if (cnt == '0)
        begin
          next_state = ADRC_INIT_PRE;
          next_cnt = cyc(ADRC_TRP_CYC);
        end
      ADRC_INIT_PRE:
        if (cnt == '0)
        begin
          next_cas = 1'b1; // cbr dummy cycle
          next_state = ADRC_INIT_RAS;
          next_cnt = cyc(ADRC_TRCD_CYC);
        end
      ADRC_INIT_RAS:
        if (cnt == '0)
        begin
          next_ras = 1'b1;
          next_dummy = dummy + 4'h1;
          next_state = ADRC_REF_RAS;
          next_isRefresh = 1'b1;
          next_cnt = cyc(ADRC_TRAS_CYC);
        end
      ADRC_IDLE:
      begin
        reqReady = (burst == '0) && !isHidden;
        if (burst != '0)
        begin
          next_isRefresh = 1'b1;
          next_addr = ROW_W'(burst); // row-only burst steps through the rows
          next_state = ADRC_PRECHARGE;
          next_cnt = cyc(ADRC_TRP_CYC);
          next_isWrite = (BURST_MODE == 2'h2);
        end
        else if (isHidden) // leading burst over, enter self refresh
        begin
          next_isRefresh = 1'b1;
          next_isWrite = 1'b0;
          next_state = ADRC_PRECHARGE;
          next_cnt = cyc(ADRC_TRP_CYC);
        end
        else if (reqValid)
        begin
          next_isWrite = (reqCmd == ADRC_CMD_WRITE);
          next_addr = reqRow;
          next_colAddr = reqCol; // request may change once taken
          next_dataOut = reqData;
          next_isRefresh = (reqCmd != ADRC_CMD_READ) && (reqCmd != ADRC_CMD_WRITE);
          if (reqCmd == ADRC_CMD_ROR)
            next_isWrite = 1'b1; // marks row-only
          if (reqCmd == ADRC_CMD_SELF)
          begin
            next_isWrite = 1'b0;
            next_isHidden = 1'b1; // marks self
            if (BURST_MODE != 2'h0)
            begin
              next_burst = 11'(ADRC_BURST_COUNT);
              next_burstAfter = 1'b0;
            end
          end
          next_state = ADRC_PRECHARGE;
          next_cnt = cyc(ADRC_TRP_CYC);
          if (reqCmd == ADRC_CMD_CLOSE || (reqCmd == ADRC_CMD_SELF && BURST_MODE != 2'h0))
            next_state = ADRC_IDLE; // nothing to close, or leading burst first
        end
      end
      ADRC_PRECHARGE:
        if (cnt == '0)
        begin
          if (isRefresh && !isWrite)
          begin
            next_cas = 1'b1; // column before row
            next_state = ADRC_CBR_CAS;
          end
          else
            next_state = ADRC_ROW;
          next_cnt = cyc(ADRC_TRCD_CYC);
        end
      ADRC_CBR_CAS:
        if (cnt == '0)
        begin
          next_ras = 1'b1;
          if (isHidden && burst == '0)
          begin
            next_state = ADRC_SELF;
            next_cnt = cyc(SELF_CYC);
          end
          else
          begin
            next_state = ADRC_REF_RAS;
            next_cnt = cyc(ADRC_TRAS_CYC);
          end
        end
      ADRC_ROW:
      begin
        next_ras = 1'b1;
        next_state = isRefresh ? ADRC_REF_RAS : ADRC_RCD;
        next_cnt = cyc(isRefresh ? ADRC_TRAS_CYC : ADRC_TRCD_CYC);
      end
      ADRC_RCD:
        if (cnt == '0)
        begin
          next_addr = colAddr;
          next_we = isWrite;
          next_doe = isWrite;
          next_oe = !isWrite;
          next_state = ADRC_COL;
          next_cnt = cyc(ADRC_TRCD_CYC);
        end
      ADRC_COL:
        if (cnt == '0)
        begin
          next_cas = 1'b1;
          next_state = ADRC_OPEN;
          next_cnt = cyc(ADRC_TCAS_CYC);
        end
      ADRC_OPEN:
        if (cnt == '0)
        begin
          if (!isWrite)
          begin
            next_rspData = dinSync;
          end
          next_rspValid = 1'b1;
          // cbr, row-only and self refresh requests wait until the row is closed and idle takes them; hidden refresh is taken here
          reqReady = (reqCmd != ADRC_CMD_CBR) && (reqCmd != ADRC_CMD_ROR)
            && (reqCmd != ADRC_CMD_SELF);
          next_cas = 1'b0;
          next_we = 1'b0;
          next_doe = 1'b0;
          next_state = ADRC_IDLE;
          next_ras = 1'b0;
          if (reqValid && (reqCmd == ADRC_CMD_READ || reqCmd == ADRC_CMD_WRITE))
          begin
            next_ras = 1'b1;
            next_isWrite = (reqCmd == ADRC_CMD_WRITE);
            next_dataOut = reqData;
            next_addr = reqCol;
            next_colAddr = reqCol;
            next_state = ADRC_RCD;
            next_cnt = cyc(0);
          end
          else if (reqValid && reqCmd == ADRC_CMD_HIDDEN)
          begin
            next_cas = 1'b1;
            next_we = we;
            next_doe = doe;
            next_state = ADRC_HIDDEN;
            next_cnt = cyc(ADRC_TRP_CYC);
          end
        end
      ADRC_HIDDEN:
        if (cnt == '0)
        begin
          if (!ras)
          begin
            next_ras = 1'b1;
            next_cnt = cyc(ADRC_TRAS_CYC);
          end
          else
          begin
            next_ras = 1'b0;
            next_cas = 1'b0;
            next_we = 1'b0;
            next_doe = 1'b0;
            next_oe = 1'b0;
            next_state = ADRC_IDLE;
          end
        end
      ADRC_REF_RAS:
        if (cnt == '0)
        begin
          next_ras = 1'b0;
          next_cas = 1'b0;
          next_isRefresh = 1'b0;
          next_isWrite = 1'b0;
          if (burst != '0)
            next_burst = burst - 11'h1;
          if (!initDone && dummy != 4'(ADRC_DUMMY_REFRESH))
          begin
            next_state = ADRC_INIT_PRE;
            next_cnt = cyc(ADRC_TRP_CYC);
          end
          else
          begin
            next_initDone = 1'b1;
            next_state = ADRC_IDLE;
          end
          if (isHidden && burst == '0 && burstAfter)
            next_isHidden = 1'b0;
        end
      ADRC_SELF:
        if (cnt == '0)
        begin
          next_ras = 1'b0;
          next_cas = 1'b0;
          next_isHidden = 1'b0;
          next_isRefresh = 1'b0;
          next_rspValid = 1'b1;
          next_state = ADRC_IDLE;
          if (BURST_MODE != 2'h0)
          begin
            next_burst = 11'(ADRC_BURST_COUNT);
            next_burstAfter = 1'b1;
          end
        end
      default:
        next_state = ADRC_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      state <= ADRC_POWERUP;
      cnt <= CNT_W'(PWRUP_CYC);
      dummy <= 4'h0;
      burst <= 11'h0;
      burstAfter <= 1'b0;
      isWrite <= 1'b0;
      isRefresh <= 1'b0;
      isHidden <= 1'b0;
      ras <= 1'b0;
      cas <= 1'b0;
      we <= 1'b0;
      oe <= 1'b0;
      doe <= 1'b0;
      addr <= '0;
      colAddr <= '0;
      dataOut <= '0;
      rspData <= '0;
      rspValid <= 1'b0;
      initDone <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      dummy <= next_dummy;
      burst <= next_burst;
      burstAfter <= next_burstAfter;
      isWrite <= next_isWrite;
      isRefresh <= next_isRefresh;
      isHidden <= next_isHidden;
      ras <= next_ras;
      cas <= next_cas;
      we <= next_we;
      oe <= next_oe;
      doe <= next_doe;
      addr <= next_addr;
      colAddr <= next_colAddr;
      dataOut <= next_dataOut;
      rspData <= next_rspData;
      rspValid <= next_rspValid;
      initDone <= next_initDone;
    end
  end

  // active-low pins
  assign rowStrobe_n = !ras;
  assign colStrobe_n = !cas;
  assign writeEnable_n = !we;
  assign outputEnable_n = !oe;
  assign dataOe_n = !doe;
endmodule : adrc_host
`default_nettype wire

// ### design/adrc_pkg.sv
// constants and types for the page-mode dram host controller
package adrc_pkg;
  localparam int ADRC_CLK_MHZ = 50;
  localparam int ADRC_CLK_NS = 20;
  // power-up wait, microseconds
  localparam int ADRC_PWRUP_US = 100;
  localparam int ADRC_PWRUP_CYC = (ADRC_PWRUP_US * 1000) / ADRC_CLK_NS + 1;
  localparam int ADRC_DUMMY_REFRESH = 8;
  // refresh burst around self refresh
  localparam int ADRC_BURST_COUNT = 1024;
  localparam int ADRC_BURST_MS = 16;
  localparam int ADRC_BURST_CYC = (ADRC_BURST_MS * 1000000) / ADRC_CLK_NS;
  // strobe phase lengths, ns
  localparam int ADRC_TRP_NS = 50;
  localparam int ADRC_TRP_CYC = (ADRC_TRP_NS + ADRC_CLK_NS - 1) / ADRC_CLK_NS;
  localparam int ADRC_TRCD_NS = 20;
  localparam int ADRC_TRCD_CYC = (ADRC_TRCD_NS + ADRC_CLK_NS - 1) / ADRC_CLK_NS;
  localparam int ADRC_TCAS_NS = 40;
  localparam int ADRC_TCAS_CYC = (ADRC_TCAS_NS + ADRC_CLK_NS - 1) / ADRC_CLK_NS;
  localparam int ADRC_TRAS_NS = 80;
  localparam int ADRC_TRAS_CYC = (ADRC_TRAS_NS + ADRC_CLK_NS - 1) / ADRC_CLK_NS;
  localparam int ADRC_TSELF_NS = 100000;
  localparam int ADRC_TSELF_CYC = (ADRC_TSELF_NS + ADRC_CLK_NS - 1) / ADRC_CLK_NS;
  // request commands
  localparam logic [2:0] ADRC_CMD_READ = 3'h0;
  localparam logic [2:0] ADRC_CMD_WRITE = 3'h1;
  localparam logic [2:0] ADRC_CMD_CBR = 3'h2;
  localparam logic [2:0] ADRC_CMD_ROR = 3'h3;
  localparam logic [2:0] ADRC_CMD_SELF = 3'h4;
  localparam logic [2:0] ADRC_CMD_HIDDEN = 3'h5;
  localparam logic [2:0] ADRC_CMD_CLOSE = 3'h6;
  typedef enum logic [3:0] {
    ADRC_POWERUP, ADRC_INIT_PRE, ADRC_INIT_RAS, ADRC_IDLE, ADRC_PRECHARGE, ADRC_ROW,
    ADRC_RCD, ADRC_COL, ADRC_OPEN, ADRC_CBR_CAS, ADRC_REF_RAS, ADRC_SELF, ADRC_HIDDEN
  } adrc_state_e;
endpackage : adrc_pkg

// ### dv/adrc_dram_model.sv
// behavioural page-mode dram module facing the host
`timescale 1ns/100ps
`default_nettype none
module adrc_dram_model (
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeEnable_n,
  input wire logic outputEnable_n,
  input wire logic [9:0] addr,
  input wire logic [31:0] dataOut,
  output logic [31:0] dataIn
);
  logic [31:0] mem [0:15];
  logic [9:0] rowAddr;
  logic rowOpen = 1'b0;
  logic reading = 1'b0;
  logic [31:0] word = 32'h0;
  // a cbr refresh leaves the row closed, write enable unused
  always @(negedge rowStrobe_n)
  begin
    #1;
    rowAddr = addr;
    rowOpen = colStrobe_n;
  end
  always @(posedge rowStrobe_n) rowOpen = 1'b0;
  // each column strobe in an open row is its own read or early write
  always @(negedge colStrobe_n)
  begin
    #1;
    reading = 1'b0;
    if (rowOpen && !writeEnable_n)
      mem[{rowAddr[1:0], addr[1:0]}] = dataOut;
    else if (rowOpen)
    begin
      reading = 1'b1;
      word = mem[{rowAddr[1:0], addr[1:0]}];
    end
  end
  always @(posedge colStrobe_n) reading = 1'b0;
  // released lines show the inverse of the last word
  assign dataIn = (reading && !outputEnable_n) ? word : ~word;
endmodule : adrc_dram_model
`default_nettype wire

// ### dv/adrc_host_asserts.sv
// port assertions for the dram host controller
`timescale 1ns/100ps
`default_nettype none
module adrc_host_asserts
  import adrc_pkg::*;
#(
  parameter int PWRUP_CYC = 20
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [2:0] reqCmd,
  input wire logic rspValid,
  input wire logic initDone,
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeEnable_n,
  input wire logic outputEnable_n,
  input wire logic dataOe_n
);
  int upCycles;
  // cycles since reset release, saturating
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      upCycles <= 0;
    else if (upCycles < PWRUP_CYC)
      upCycles <= upCycles + 1;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_powerup_quiet: assert property (upCycles < PWRUP_CYC |-> rowStrobe_n)
    else $error("row strobe before power-up wait");
  a_dummy_cbr: assert property ($fell(rowStrobe_n) && !initDone |-> !colStrobe_n)
    else $error("non-refresh row cycle before init");
  a_ready_init: assert property (reqReady |-> initDone)
    else $error("request taken before init");
  a_rsp_init: assert property (rspValid |-> initDone)
    else $error("response before init");
  a_rsp_single: assert property (rspValid |=> !rspValid)
    else $error("response longer than one cycle");
  a_cbr_order: assert property ($fell(rowStrobe_n) && !colStrobe_n |-> !$past(colStrobe_n))
    else $error("column strobe not ahead of row strobe");
  a_cbr_float: assert property ($fell(colStrobe_n) && rowStrobe_n |-> dataOe_n)
    else $error("host drives data in refresh");
  a_early_write: assert property ($fell(colStrobe_n) && !writeEnable_n |-> !dataOe_n)
    else $error("write data missing at column strobe");
  a_no_clash: assert property (!dataOe_n |-> outputEnable_n)
    else $error("host drives data with output enabled");
  a_page_hold: assert property (reqValid && reqReady && !rowStrobe_n && reqCmd <= ADRC_CMD_WRITE
    |=> !rowStrobe_n [*2])
    else $error("row closed between page accesses");
endmodule : adrc_host_asserts
bind adrc_host adrc_host_asserts #(.PWRUP_CYC(PWRUP_CYC)) u_asserts (.clock(clock),
  .arst_n(arst_n), .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .rspValid(rspValid),
  .initDone(initDone), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
  .writeEnable_n(writeEnable_n), .outputEnable_n(outputEnable_n), .dataOe_n(dataOe_n));
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the dram host controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import adrc_pkg::*;
  localparam int PW = 20;
  logic clock, arst_n, reqValid, reqReady, rspValid, initDone, cbrPhase;
  logic rowStrobe_n, colStrobe_n, writeEnable_n, outputEnable_n, dataOe_n;
  logic [2:0] reqCmd;
  logic [9:0] reqRow, reqCol, addr;
  logic [31:0] reqData, rspData, dataIn, dataOut;
  int mismatches, tests_run, rowFalls, cbrFalls, refDrive, cycles, firstFall, n, f0, r0, d0;
  logic [31:0] rdq[$];
  logic reqValidB, readyCbr, readyRor, rspCbr, rspRor, rasCbr_n, casCbr_n, rasRor_n, casRor_n;
  int cbrB, rorB, cbrExit, rorExit;
  adrc_host #(.PWRUP_CYC(PW), .SELF_CYC(10), .BURST_MODE(2'h0)) uut (.clock(clock),
    .arst_n(arst_n), .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .reqRow(reqRow),
    .reqCol(reqCol), .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
    .initDone(initDone), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
    .writeEnable_n(writeEnable_n), .outputEnable_n(outputEnable_n), .addr(addr),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n));
  adrc_dram_model model (.rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
    .writeEnable_n(writeEnable_n), .outputEnable_n(outputEnable_n), .addr(addr),
    .dataOut(dataOut), .dataIn(dataIn));
  // burst refresh styles around self refresh; refresh needs no read data
  adrc_host #(.PWRUP_CYC(PW), .SELF_CYC(10), .BURST_MODE(2'h1)) uutCbr (.clock(clock),
    .arst_n(arst_n), .reqValid(reqValidB), .reqReady(readyCbr), .reqCmd(reqCmd),
    .reqRow(reqRow), .reqCol(reqCol), .reqData(reqData), .rspValid(rspCbr), .rspData(),
    .initDone(), .rowStrobe_n(rasCbr_n), .colStrobe_n(casCbr_n), .writeEnable_n(),
    .outputEnable_n(), .addr(), .dataIn(32'h0), .dataOut(), .dataOe_n());
  adrc_host #(.PWRUP_CYC(PW), .SELF_CYC(10), .BURST_MODE(2'h2)) uutRor (.clock(clock),
    .arst_n(arst_n), .reqValid(reqValidB), .reqReady(readyRor), .reqCmd(reqCmd),
    .reqRow(reqRow), .reqCol(reqCol), .reqData(reqData), .rspValid(rspRor), .rspData(),
    .initDone(), .rowStrobe_n(rasRor_n), .colStrobe_n(casRor_n), .writeEnable_n(),
    .outputEnable_n(), .addr(), .dataIn(32'h0), .dataOut(), .dataOe_n());
  // refresh kinds seen on the burst instances
  always @(negedge rasCbr_n)
    if (casCbr_n === 1'b0)
      cbrB++;
  always @(negedge rasRor_n)
    if (casRor_n === 1'b1)
      rorB++;
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // strobe watch and response capture
  always @(negedge rowStrobe_n)
  begin
    if (rowFalls == 0)
      firstFall = cycles;
    rowFalls++;
    if (colStrobe_n === 1'b0)
      cbrFalls++;
  end
  always @(negedge colStrobe_n) cbrPhase = rowStrobe_n;
  always @(posedge colStrobe_n) cbrPhase = 1'b0;
  always @(posedge clock)
  begin
    cycles++;
    if (rspValid === 1'b1)
      rdq.push_back(rspData);
    if (cbrPhase && !colStrobe_n && dataOe_n !== 1'b1)
      refDrive++;
    if (rspCbr === 1'b1)
      cbrExit = cbrB;
    if (rspRor === 1'b1)
      rorExit = rorB;
  end
  task check(input string w, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask : check
  // hold a request until the edge that takes it
  task send(input logic [2:0] c, input logic [9:0] r, input logic [9:0] k, input logic [31:0] d);
    reqValid <= 1'b1;
    reqCmd <= c;
    reqRow <= r;
    reqCol <= k;
    reqData <= d;
    @(negedge clock);
    for (n = 0; n < 2000 && reqReady !== 1'b1; n++) @(negedge clock);
    check("request taken", 32'h1, 32'(n < 2000));
    @(posedge clock);
  endtask : send
  task waitq(input int k);
    for (n = 0; n < 500 && rdq.size() < k; n++) @(posedge clock);
  endtask : waitq
  task rd(input logic [9:0] k, input logic [31:0] e, input string w);
    rdq.delete();
    send(ADRC_CMD_READ, 10'h5, k, 32'h0);
    reqValid <= 1'b0;
    waitq(1);
    check(w, e, rdq[0]);
  endtask : rd
  task t_init;
    for (n = 0; n < 3000 && initDone !== 1'b1; n++) @(posedge clock);
    check("dummy refresh count", 32'h8, 32'(cbrFalls));
    check("power-up wait", 32'h1, 32'(firstFall > PW + 6));
    $display("test init done");
  endtask : t_init
  task t_page;
    rdq.delete();
    r0 = rowFalls;
    send(ADRC_CMD_WRITE, 10'h5, 10'h1, 32'ha5a5_0f0f);
    send(ADRC_CMD_READ, 10'h5, 10'h1, 32'h0);
    send(ADRC_CMD_WRITE, 10'h5, 10'h2, 32'h5a5a_f0f0);
    send(ADRC_CMD_READ, 10'h5, 10'h2, 32'h0);
    send(ADRC_CMD_CLOSE, 10'h5, 10'h2, 32'h0);
    reqValid <= 1'b0;
    waitq(4);
    check("page read one", 32'ha5a5_0f0f, rdq[1]);
    check("page read two", 32'h5a5a_f0f0, rdq[3]);
    check("row cycles in page", 32'h1, 32'(rowFalls - r0));
    $display("test page done");
  endtask : t_page
  task t_refresh;
    f0 = cbrFalls;
    r0 = rowFalls;
    d0 = refDrive;
    send(ADRC_CMD_CBR, 10'h3, 10'h0, 32'h0);
    send(ADRC_CMD_ROR, 10'h3, 10'h0, 32'h0);
    rd(10'h1, 32'ha5a5_0f0f, "data after refresh");
    check("cbr cycles", 32'h1, 32'(cbrFalls - f0));
    check("row cycles", 32'h3, 32'(rowFalls - r0));
    check("data driven in refresh", 32'(d0), 32'(refDrive));
    $display("test refresh done");
  endtask : t_refresh
  task t_self;
    rdq.delete();
    r0 = rowFalls;
    d0 = refDrive;
    send(ADRC_CMD_SELF, 10'h0, 10'h0, 32'h0);
    reqValid <= 1'b0;
    waitq(1);
    check("self exit", 32'h1, 32'(rdq.size()));
    check("no burst around self", 32'h1, 32'(rowFalls - r0));
    check("data driven in self", 32'(d0), 32'(refDrive));
    rd(10'h2, 32'h5a5a_f0f0, "data after self");
    $display("test self done");
  endtask : t_self
  task t_hidden;
    rdq.delete();
    f0 = cbrFalls;
    send(ADRC_CMD_READ, 10'h5, 10'h1, 32'h0);
    send(ADRC_CMD_HIDDEN, 10'h5, 10'h1, 32'h0);
    reqValid <= 1'b0;
    waitq(1);
    check("hidden read", 32'ha5a5_0f0f, rdq[0]);
    rd(10'h2, 32'h5a5a_f0f0, "data after hidden");
    check("hidden refresh cycles", 32'h1, 32'(cbrFalls - f0));
    $display("test hidden done");
  endtask : t_hidden
  // self refresh with a refresh burst on each side, both burst styles at once
  task t_burst;
    f0 = cbrB;
    r0 = rorB;
    d0 = cycles;
    reqCmd <= ADRC_CMD_SELF;
    reqValidB <= 1'b1;
    @(negedge clock);
    for (n = 0; n < 100 && (readyCbr & readyRor) !== 1'b1; n++) @(negedge clock);
    check("burst self taken", 32'h1, 32'(n < 100));
    @(posedge clock);
    reqValidB <= 1'b0;
    @(negedge clock);
    for (n = 0; n < 30000 && (readyCbr & readyRor) !== 1'b1; n++) @(negedge clock);
    check("burst run ended", 32'h1, 32'(n < 30000));
    check("cbr burst before self", 32'h401, 32'(cbrExit - f0));
    check("cbr burst after self", 32'h400, 32'(cbrB - cbrExit));
    check("row-only burst before self", 32'h400, 32'(rorExit - r0));
    check("row-only burst after self", 32'h400, 32'(rorB - rorExit));
    check("burst span", 32'h1, 32'(cycles - d0 < ADRC_BURST_CYC));
    $display("test burst done");
  endtask : t_burst
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    arst_n = 1'b0;
    reqValid = 1'b0;
    reqCmd = 3'h0;
    reqRow = 10'h0;
    reqCol = 10'h0;
    reqData = 32'h0;
    cbrPhase = 1'b0;
    reqValidB = 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    t_init();
    t_page();
    t_refresh();
    t_self();
    t_hidden();
    t_burst();
    give_verdict();
  end
  // watchdog, the two refresh bursts take about 25000 cycles, the rest far less
  initial
  begin
    #1000000;
    mismatches++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
